// file: ipa_arbiter.sv
// Purpose: interrupt recognition, acknowledge arbitration, reset state
// Assumes: request lines synchronous to clk_i; bus handshake by outside
// Notes:   core sequencing abstracted to boundary and cycle-done strobes
//
// Contract
// (RULE1) reset acts only once the current bus cycle finishes
// (RULE2) master reset clears trace bits, sets supervisor, mask to seven
// (RULE3) master reset sets vector table base to zero
// (RULE4) after reset fetch stack pointer then program counter, then run
// (RULE5) reset cause flags set per source, updated on reset pin release
// (RULE6) seven request lines, level 1 lowest, external pins count as unit
// (RULE7) requests at or below mask ignored, except level seven
// (RULE8) requesters hold line low until acknowledge of their level
// (RULE9) level seven edge or mask drop from seven raises nonmaskable
// (RULE10) request valid only after two consecutive sampled periods low
// (RULE11) valid requests pend until boundary or higher exception done
// (RULE12) level not latched; highest unmasked pending level wins
// (RULE13) acknowledge drives level on address, copies it into mask
// (RULE14) requesters respond only when level matches, after arbitration
// (RULE15) serial contention of 4-bit values; zero winner means spurious
// (RULE16) integration unit value resets to 15, others to zero
// (RULE17) arbitration always; external only if unit wins; none gives error
// (RULE18) internal winner supplies vector and terminates the cycle
// (RULE19) external: vector with acknowledge, autovector, or timeout error
// (RULE20) chip-select match only after cycle passed to external bus
// (RULE21) periodic timer level from its field; zero disables it
// (RULE22) same level in unit: periodic timer first, then pins; code gives neither precedence, both take the external cycle
// (RULE23) acknowledge drives function codes all ones, level on addr 3:1
// (RULE24) autovector termination makes vector from acknowledged level
// (RULE25) vector address is base plus four times vector number
`timescale 1ns/1ps
`default_nettype none
module ipa_arbiter
  import ipa_pkg::*;
#(
  parameter int NMOD = 4
) (
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  // reset control
  input  wire logic                  reset_req_i,
  input  wire logic                  reset_pin_n_i,
  input  wire logic [IPA_CAUSES-1:0] reset_cause_i,
  input  wire logic                  bus_cycle_done_i,
  output logic                       master_reset_line_o,
  output logic [IPA_CAUSES-1:0]      reset_cause_register_o,
  // status and vector base
  input  wire logic                  vbase_we_i,
  input  wire logic [31:0]           vbase_wdata_i,
  input  wire logic                  mask_we_i,
  input  wire logic [2:0]            mask_wdata_i,
  output logic [2:0]                 priority_mask_field_o,
  output logic                       trace_bit_low_o,
  output logic                       trace_bit_high_o,
  output logic                       supervisor_o,
  output logic [31:0]                vector_table_base_o,
  // requests
  input  wire logic [7:1]            irq_n_i,
  input  wire logic [2:0]            periodic_irq_level_i,
  input  wire logic                  periodic_irq_i,
  input  wire logic                  insn_boundary_i,
  input  wire logic                  exc_done_i,
  // modules: request level, arbitration value, vector
  input  wire logic [NMOD*3-1:0]     mod_level_i,
  input  wire logic [NMOD*4-1:0]     mod_arb_i,
  input  wire logic [NMOD*8-1:0]     mod_vector_i,
  input  wire logic [3:0]            siu_arb_i,
  input  wire logic                  siu_arb_we_i,
  // external acknowledge
  input  wire logic [7:0]            ext_data_i,
  input  wire logic                  data_size_acknowledge_i,
  input  wire logic                  autovector_request_i,
  // outputs to core and bus
  output logic                       nmi_o,
  output logic                       iack_o,
  output logic [2:0]                 function_code_lines_o,
  output logic [3:1]                 iack_addr_o,
  output logic                       ext_iack_o,
  output logic                       cs_match_en_o,
  output logic                       bus_error_signal_o,
  output logic                       spurious_o,
  output logic [7:0]                 vector_o,
  output logic [31:0]                vector_addr_o,
  output logic                       vector_valid_o,
  output logic                       fetch_o,
  output logic [31:0]                fetch_addr_o,
  input  wire logic [31:0]           fetch_data_i,
  input  wire logic                  fetch_done_i,
  output logic [31:0]                stack_ptr_o,
  output logic [31:0]                prog_cnt_o,
  output logic                       running_o
);

  // ************************************************************
  // reset request, gated to the end of a bus cycle
  // ************************************************************
  logic                  mrst_reg;
  logic                  pin_q_reg;
  logic [IPA_CAUSES-1:0] cause_acc_reg;

  // a write in flight must not be torn, so wait for cycle end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mrst_reg <= 1'b1;
    end else if (reset_req_i && bus_cycle_done_i) begin
      mrst_reg <= 1'b1; // RULE1
    end else if (!reset_req_i) begin
      mrst_reg <= 1'b0;
    end
  end
  assign master_reset_line_o = mrst_reg;

  // cause flags collect while pin low, publish on its release
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_q_reg              <= 1'b1;
      cause_acc_reg          <= '0;
      reset_cause_register_o <= '0;
    end else begin
      pin_q_reg <= reset_pin_n_i;
      if (!reset_pin_n_i) begin
        cause_acc_reg <= cause_acc_reg | reset_cause_i;
      end
      if (reset_pin_n_i && !pin_q_reg) begin
        reset_cause_register_o <= cause_acc_reg | reset_cause_i; // RULE5
        cause_acc_reg          <= '0;
      end
    end
  end

  // ************************************************************
  // request sampling and validation
  // ************************************************************
  logic [7:1] s1_reg;
  logic [7:1] s2_reg;
  logic [7:1] valid;
  logic       l7_prev_reg;
  logic [2:0] mask_prev_reg;
  logic       nmi_pend_reg;

  // only the rising edge is used; dual edges avoided on purpose
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= ~irq_n_i;
      s2_reg <= s1_reg;
    end
  end
  assign valid = s1_reg & s2_reg; // RULE10 RULE8

  // ************************************************************
  // level selection among unit and module sources
  // ************************************************************
  logic [7:1] req_lv;
  logic [2:0] top_lv;
  logic       top_ok;
  logic [2:0] state_mask;

  always_comb begin
    req_lv = valid; // RULE6
    if (periodic_irq_i && periodic_irq_level_i != IPA_LEVEL_NONE) begin
      req_lv[periodic_irq_level_i] = 1'b1; // RULE21
    end
    for (int m = 0; m < NMOD; m++) begin
      if (mod_level_i[m*3 +: 3] != IPA_LEVEL_NONE) begin
        req_lv[mod_level_i[m*3 +: 3]] = 1'b1;
      end
    end
  end

  // highest unmasked level, recomputed every cycle
  always_comb begin
    top_lv = IPA_LEVEL_NONE;
    for (int l = 1; l < IPA_LEVELS; l++) begin
      if (req_lv[l] && 3'(l) > state_mask) begin
        top_lv = 3'(l); // RULE7 RULE12
      end
    end
    if (nmi_pend_reg) begin
      top_lv = IPA_MASK_MAX; // RULE9
    end
    top_ok = top_lv != IPA_LEVEL_NONE;
  end

  // level seven only fires on new edge or mask dropping from seven
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      l7_prev_reg   <= 1'b0;
      mask_prev_reg <= IPA_MASK_MAX;
      nmi_pend_reg  <= 1'b0;
    end else begin
      l7_prev_reg   <= req_lv[7];
      mask_prev_reg <= state_mask;
      if ((req_lv[7] && !l7_prev_reg) ||
          (req_lv[7] && mask_prev_reg == IPA_MASK_MAX &&
           state_mask != IPA_MASK_MAX)) begin
        nmi_pend_reg <= 1'b1; // RULE9
      end else if (iack_o && iack_addr_o == IPA_MASK_MAX) begin
        nmi_pend_reg <= 1'b0;
      end
    end
  end
  assign nmi_o = nmi_pend_reg;

  // ************************************************************
  // serial contention of arbitration values
  // ************************************************************
  logic [3:0] siu_arb_reg;
  logic [3:0] win_arb;
  logic [7:0] win_vec;
  logic       siu_wins;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      siu_arb_reg <= IPA_ARB_SIU_RST; // RULE16
    end else if (siu_arb_we_i) begin
      siu_arb_reg <= siu_arb_i;
    end
  end

  // unit contends when pins or timer request the acknowledged level
  always_comb begin
    win_arb  = IPA_ARB_ZERO;
    win_vec  = IPA_VEC_SPUR;
    siu_wins = 1'b0;
    if (valid[iack_addr_o] ||
        (periodic_irq_i && periodic_irq_level_i == iack_addr_o)) begin
      win_arb  = siu_arb_reg; // RULE22
      siu_wins = 1'b1;
    end
    for (int m = 0; m < NMOD; m++) begin
      if (mod_level_i[m*3 +: 3] == iack_addr_o &&
          mod_arb_i[m*4 +: 4] > win_arb) begin
        win_arb  = mod_arb_i[m*4 +: 4]; // RULE14 RULE15
        win_vec  = mod_vector_i[m*8 +: 8];
        siu_wins = 1'b0;
      end
    end
  end

  // ************************************************************
  // acknowledge and reset-vector sequencer
  // ************************************************************
  ipa_state_e                state_reg;
  logic [$clog2(IPA_BUSMON_CYC+1)-1:0] mon_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg             <= IPA_RV0;
      mon_reg               <= '0;
      iack_o                <= 1'b0;
      iack_addr_o           <= IPA_LEVEL_NONE;
      function_code_lines_o <= '0;
      ext_iack_o            <= 1'b0;
      bus_error_signal_o    <= 1'b0;
      spurious_o            <= 1'b0;
      vector_o              <= IPA_VEC_SPUR;
      vector_valid_o        <= 1'b0;
      fetch_o               <= 1'b0;
      fetch_addr_o          <= IPA_RST_VEC_A0;
      stack_ptr_o           <= '0;
      prog_cnt_o            <= '0;
    end else if (mrst_reg) begin
      state_reg      <= IPA_RV0; // RULE1
      iack_o         <= 1'b0;
      bus_error_signal_o <= 1'b0;
      ext_iack_o     <= 1'b0;
      vector_valid_o <= 1'b0;
      fetch_o        <= 1'b0;
    end else begin
      vector_valid_o     <= 1'b0;
      bus_error_signal_o <= 1'b0;
      case (state_reg)
        IPA_RV0: begin
          fetch_o      <= 1'b1;
          fetch_addr_o <= vector_table_base_o + IPA_RST_VEC_A0;
          if (fetch_o && fetch_done_i) begin
            stack_ptr_o  <= fetch_data_i; // RULE4
            fetch_addr_o <= vector_table_base_o + IPA_RST_VEC_A1;
            state_reg    <= IPA_RV1;
          end
        end
        IPA_RV1: begin
          if (fetch_done_i) begin
            prog_cnt_o <= fetch_data_i; // RULE4
            fetch_o    <= 1'b0;
            state_reg  <= IPA_IDLE;
          end
        end
        IPA_IDLE: begin
          if (top_ok && (insn_boundary_i || exc_done_i)) begin
            iack_o                <= 1'b1; // RULE11
            iack_addr_o           <= top_lv; // RULE13 RULE23
            function_code_lines_o <= IPA_FCODE_CPU; // RULE23
            state_reg             <= IPA_ARB;
          end
        end
        IPA_ARB: begin
          mon_reg <= '0;
          if (win_arb == IPA_ARB_ZERO) begin
            bus_error_signal_o <= 1'b1; // RULE17 RULE15
            spurious_o         <= 1'b1;
            vector_o           <= IPA_VEC_SPUR;
            state_reg          <= IPA_VEC;
          end else if (siu_wins) begin
            ext_iack_o <= 1'b1; // RULE17 RULE20
            state_reg  <= IPA_EXT;
          end else begin
            spurious_o <= 1'b0;
            vector_o   <= win_vec; // RULE18
            state_reg  <= IPA_VEC;
          end
        end
        IPA_EXT: begin
          mon_reg <= mon_reg + 1'b1;
          if (autovector_request_i) begin
            vector_o   <= IPA_VEC_AUTO0 + {5'h0, iack_addr_o}; // RULE24
            spurious_o <= 1'b0;
            state_reg  <= IPA_VEC;
          end else if (data_size_acknowledge_i) begin
            vector_o   <= ext_data_i; // RULE19
            spurious_o <= 1'b0;
            state_reg  <= IPA_VEC;
          end else if (mon_reg == IPA_BUSMON_CYC[$bits(mon_reg)-1:0]) begin
            bus_error_signal_o <= 1'b1; // RULE19
            spurious_o         <= 1'b1;
            vector_o           <= IPA_VEC_SPUR;
            state_reg          <= IPA_VEC;
          end
        end
        IPA_VEC: begin
          iack_o         <= 1'b0;
          ext_iack_o     <= 1'b0;
          vector_valid_o <= 1'b1;
          state_reg      <= IPA_IDLE;
        end
        default: state_reg <= IPA_IDLE;
      endcase
    end
  end
  assign cs_match_en_o = ext_iack_o; // RULE20
  assign running_o     = state_reg != IPA_RV0 && state_reg != IPA_RV1;
  assign vector_addr_o = vector_table_base_o + {22'h0, vector_o, 2'h0}; // RULE25

  // ************************************************************
  // status bits and vector base
  // ************************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_mask          <= IPA_MASK_MAX;
      trace_bit_low_o     <= 1'b0;
      trace_bit_high_o    <= 1'b0;
      supervisor_o        <= 1'b1;
      vector_table_base_o <= IPA_VBASE_RST;
    end else if (mrst_reg) begin
      state_mask          <= IPA_MASK_MAX; // RULE2
      trace_bit_low_o     <= 1'b0; // RULE2
      trace_bit_high_o    <= 1'b0;
      supervisor_o        <= 1'b1;
      vector_table_base_o <= IPA_VBASE_RST; // RULE3
    end else begin
      if (state_reg == IPA_IDLE && top_ok &&
          (insn_boundary_i || exc_done_i)) begin
        state_mask       <= top_lv; // RULE13
        supervisor_o     <= 1'b1;
        trace_bit_low_o  <= 1'b0;
        trace_bit_high_o <= 1'b0;
      end else if (mask_we_i) begin
        state_mask <= mask_wdata_i;
      end
      if (vbase_we_i) begin
        vector_table_base_o <= vbase_wdata_i;
      end
    end
  end
  assign priority_mask_field_o = state_mask;

endmodule
`default_nettype wire

// file: ipa_pkg.sv
// Purpose: shared constants for the interrupt priority arbitration block
// Assumes: one 40 MHz clock, asynchronous active-low reset
// Notes:   all timing and encodings referenced by the arbiter live here
package ipa_pkg;

  // ************************************************************
  // widths and encodings
  // ************************************************************
  localparam int          IPA_LEVELS      = 7;
  localparam logic [2:0]  IPA_MASK_MAX    = 3'h7;
  localparam logic [2:0]  IPA_LEVEL_NONE  = 3'h0;
  localparam logic [3:0]  IPA_ARB_ZERO    = 4'h0;
  localparam logic [3:0]  IPA_ARB_SIU_RST = 4'hf;
  localparam logic [2:0]  IPA_FCODE_CPU   = 3'h7;
  localparam logic [31:0] IPA_VBASE_RST   = 32'h0000_0000;
  localparam logic [7:0]  IPA_VEC_SPUR    = 8'h18;
  localparam logic [7:0]  IPA_VEC_AUTO0   = 8'h18;
  localparam logic [31:0] IPA_RST_VEC_A0  = 32'h0000_0000;
  localparam logic [31:0] IPA_RST_VEC_A1  = 32'h0000_0004;
  localparam int          IPA_CAUSES      = 4;

  // bus monitor timeout on external acknowledge
  localparam int          IPA_BUSMON_NS   = 400;
  localparam int          IPA_CLK_NS      = 25;
  localparam int          IPA_BUSMON_CYC  =
    (IPA_BUSMON_NS + IPA_CLK_NS - 1) / IPA_CLK_NS;

  typedef enum logic [2:0] {
    IPA_IDLE, IPA_ARB, IPA_EXT, IPA_VEC, IPA_RV0, IPA_RV1, IPA_RUN
  } ipa_state_e;

endpackage

// file: ipa_arbiter_properties.sv
// Purpose: concurrent checks on the arbiter ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   attached by the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module ipa_arbiter_chk
  import ipa_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        master_reset_line_o,
  input wire logic        nmi_o,
  input wire logic [2:0]  priority_mask_field_o,
  input wire logic        trace_bit_low_o,
  input wire logic        trace_bit_high_o,
  input wire logic        supervisor_o,
  input wire logic [31:0] vector_table_base_o,
  input wire logic        iack_o,
  input wire logic [2:0]  function_code_lines_o,
  input wire logic [3:1]  iack_addr_o,
  input wire logic        ext_iack_o,
  input wire logic        cs_match_en_o,
  input wire logic        bus_error_signal_o,
  input wire logic        spurious_o,
  input wire logic [7:0]  vector_o,
  input wire logic [31:0] vector_addr_o,
  input wire logic        vector_valid_o
);
  // bus monitor count plus a few cycles of slack
  localparam int BM_MAX = 24;
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // second cycle of master reset: state registers have landed
  a_rst_state: assert property (master_reset_line_o ##1 master_reset_line_o
    |-> priority_mask_field_o == IPA_MASK_MAX && supervisor_o
    && !trace_bit_low_o && !trace_bit_high_o)
    else $error("reset state wrong");
  a_rst_base: assert property (master_reset_line_o ##1 master_reset_line_o
    |-> vector_table_base_o == IPA_VBASE_RST)
    else $error("vector base not cleared");
  a_ack_masked: assert property ($rose(iack_o) |-> iack_addr_o == 3'h7
    || iack_addr_o > $past(priority_mask_field_o))
    else $error("masked level acknowledged");
  a_mask_copy: assert property ($rose(iack_o)
    |-> priority_mask_field_o == iack_addr_o) else $error("mask not copied");
  a_ack_space: assert property (iack_o
    |-> function_code_lines_o == IPA_FCODE_CPU) else $error("bad space code");
  a_nmi_ack: assert property ($rose(iack_o) && iack_addr_o == 3'h7
    |-> $past(nmi_o)) else $error("level seven without edge");
  a_ack_ends: assert property ($rose(iack_o) |-> ##[2:40] vector_valid_o)
    else $error("acknowledge never ends");
  a_busmon_bound: assert property ($rose(ext_iack_o)
    |-> ##[1:BM_MAX] !ext_iack_o) else $error("external cycle hangs");
  a_bus_error_signal_pulse: assert property (bus_error_signal_o |=> !bus_error_signal_o)
    else $error("bus error too long");
  a_cs_gate: assert property (cs_match_en_o
    |-> ext_iack_o && iack_o && $past(iack_o))
    else $error("chip select before external pass");
  a_spur_vector: assert property (vector_valid_o && spurious_o
    |-> vector_o == IPA_VEC_SPUR) else $error("bad spurious vector");
  a_vector_addr: assert property (vector_valid_o |-> vector_addr_o
    == vector_table_base_o + 32'(vector_o) * 32'h4)
    else $error("bad vector address");
  c_internal: cover property (vector_valid_o && !spurious_o);
  c_spurious: cover property (vector_valid_o && spurious_o);
  c_bus_error: cover property (bus_error_signal_o);
endmodule
bind ipa_arbiter ipa_arbiter_chk i_chk (
  .clk_i, .nrst_i, .master_reset_line_o, .priority_mask_field_o,
  .trace_bit_low_o, .trace_bit_high_o, .supervisor_o, .vector_table_base_o,
  .nmi_o, .iack_o, .function_code_lines_o, .iack_addr_o, .ext_iack_o,
  .cs_match_en_o, .bus_error_signal_o, .spurious_o, .vector_o,
  .vector_addr_o, .vector_valid_o);
`default_nettype wire

// file: ipa_far_end.sv
// Purpose: external interrupting device and reset-vector memory
// Assumes: mode 0 silent, 1 prompt ack, 2 autovector, 3 slow ack
// Notes:   released data lines show inverted values, never old ones
`timescale 1ns/1ps
`default_nettype none
module ipa_far_end
  import ipa_pkg::*;
#(
  parameter logic [31:0] SP_WORD = 32'h0000_2000,
  parameter logic [31:0] PC_WORD = 32'h0000_0400,
  parameter logic [7:0]  EXT_VEC = 8'h40
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic        ext_iack_i,
  input  wire logic        fetch_i,
  input  wire logic [31:0] fetch_addr_i,
  output logic [7:0]       ext_data_o,
  output logic             data_size_acknowledge_o,
  output logic             autovector_request_o,
  output logic [31:0]      fetch_data_o,
  output logic             fetch_done_o
);
  logic [2:0] ack_cnt_reg;
  logic [1:0] fet_cnt_reg;
  logic       resp;
  // ************************************************************
  // acknowledge responder
  // ************************************************************
  // counts only while the cycle reached the external bus
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) ack_cnt_reg <= 3'h0;
    else if (!ext_iack_i) ack_cnt_reg <= 3'h0;
    else if (ack_cnt_reg != 3'h7) ack_cnt_reg <= ack_cnt_reg + 3'h1;
  end
  assign resp = ext_iack_i
    && ack_cnt_reg >= (mode_i == 2'h3 ? 3'h6 : 3'h2);
  assign data_size_acknowledge_o = resp && mode_i[0];
  assign autovector_request_o = resp && mode_i == 2'h2;
  assign ext_data_o = data_size_acknowledge_o ? EXT_VEC : ~EXT_VEC;
  // ************************************************************
  // reset vector memory, three-cycle access
  // ************************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) fet_cnt_reg <= 2'h0;
    else if (!fetch_i || fet_cnt_reg == 2'h2) fet_cnt_reg <= 2'h0;
    else fet_cnt_reg <= fet_cnt_reg + 2'h1;
  end
  assign fetch_done_o = fetch_i && fet_cnt_reg == 2'h2;
  assign fetch_data_o = !fetch_done_o ? ~SP_WORD
    : (fetch_addr_i[2] ? PC_WORD : SP_WORD);
endmodule
`default_nettype wire

// file: ipa_arbiter_tb.sv
// Purpose: directed test of reset state, recognition and acknowledge
// Assumes: inputs change 2 ns after the rising edge
// Notes:   unit arbitration value left at its reset value of 15
`timescale 1ns/1ps
`default_nettype none
module ipa_arbiter_tb;
  import ipa_pkg::*;
  localparam logic [31:0] SPW = 32'h0000_2000;
  localparam logic [31:0] PCW = 32'h0000_0400;
  localparam logic [7:0]  XV  = 8'h40;
  logic        clk_i = 1'b0, nrst_i = 1'b0, rreq = 1'b0, pin_n = 1'b1;
  logic        bdone = 1'b0, vb_we = 1'b0, m_we = 1'b0, per = 1'b0;
  logic        bnd = 1'b1;
  logic [3:0]  cause = 4'h0, cause_reg;
  logic [2:0]  m_wd = 3'h0, per_lvl = 3'h0, mask, ack_lvl;
  logic [7:1]  irq_n = 7'h7f;
  logic [11:0] m_lvl = 12'h0;
  logic [15:0] m_arb = 16'h0;
  logic [31:0] m_vec = 32'h0, vbase = 32'h0, fdata, faddr, sp, pc, vbo;
  logic [31:0] vaddr;
  logic [1:0]  mode = 2'h0;
  logic [7:0]  xdat, vec;
  logic        size_ack, auto_req, fdone, fetch, xiack, mrst, iack, vvalid;
  logic        bus_err, spur, run, trc_lo, trc_hi, sup, err_seen, spur_seen;
  logic [7:0]  xtab [4];
  int          bad_count = 0, n_tests = 0, cycles = 0;
  ipa_arbiter i_dut (
    .clk_i, .nrst_i, .reset_req_i(rreq), .reset_pin_n_i(pin_n),
    .reset_cause_i(cause), .bus_cycle_done_i(bdone),
    .master_reset_line_o(mrst), .reset_cause_register_o(cause_reg),
    .vbase_we_i(vb_we), .vbase_wdata_i(vbase), .mask_we_i(m_we),
    .mask_wdata_i(m_wd), .priority_mask_field_o(mask),
    .trace_bit_low_o(trc_lo), .trace_bit_high_o(trc_hi), .supervisor_o(sup),
    .vector_table_base_o(vbo), .irq_n_i(irq_n),
    .periodic_irq_level_i(per_lvl), .periodic_irq_i(per),
    .insn_boundary_i(bnd), .exc_done_i(1'b0), .mod_level_i(m_lvl),
    .mod_arb_i(m_arb), .mod_vector_i(m_vec), .siu_arb_i(4'hf),
    .siu_arb_we_i(1'b0), .ext_data_i(xdat),
    .data_size_acknowledge_i(size_ack), .autovector_request_i(auto_req),
    .nmi_o(), .iack_o(iack), .function_code_lines_o(),
    .iack_addr_o(ack_lvl), .ext_iack_o(xiack), .cs_match_en_o(),
    .bus_error_signal_o(bus_err), .spurious_o(spur), .vector_o(vec),
    .vector_addr_o(vaddr), .vector_valid_o(vvalid), .fetch_o(fetch),
    .fetch_addr_o(faddr), .fetch_data_i(fdata), .fetch_done_i(fdone),
    .stack_ptr_o(sp), .prog_cnt_o(pc), .running_o(run));
  ipa_far_end #(.SP_WORD(SPW), .PC_WORD(PCW), .EXT_VEC(XV)) i_far (
    .clk_i, .nrst_i, .mode_i(mode), .ext_iack_i(xiack), .fetch_i(fetch),
    .fetch_addr_i(faddr), .ext_data_o(xdat),
    .data_size_acknowledge_o(size_ack), .autovector_request_o(auto_req),
    .fetch_data_o(fdata), .fetch_done_o(fdone));
  // ************************************************************
  // clock, watchdog and helpers
  // ************************************************************
  always #12.5 clk_i = ~clk_i;
  // whole run is well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic set_mask(input logic [2:0] m);
    m_wd = m;
    m_we = 1'b1;
    cyc(1);
    m_we = 1'b0;
  endtask
  task automatic set_base(input logic [31:0] b);
    vbase = b;
    vb_we = 1'b1;
    cyc(1);
    vb_we = 1'b0;
  endtask
  task automatic wait_run();
    int k;
    k = 0;
    while (run !== 1'b1 && k < 60) begin cyc(1); k++; end
    chk(sp, SPW);
    chk(pc, PCW);
  endtask
  // drops every request source, then clears the mask to zero
  task automatic clr();
    irq_n = 7'h7f;
    m_lvl = 12'h0;
    per = 1'b0;
    cyc(2);
    set_mask(3'h0);
  endtask
  task automatic quiet(input int n);
    logic s;
    s = 1'b0;
    repeat (n) begin cyc(1); if (iack === 1'b1) s = 1'b1; end
    chk(s, 1'b0);
  endtask
  task automatic ack(input logic [2:0] lvl, input logic [7:0] v);
    int k;
    k = 0;
    err_seen = 1'b0;
    while (iack !== 1'b1 && k < 40) begin cyc(1); k++; end
    chk(ack_lvl, lvl);
    chk(mask, lvl);
    while (vvalid !== 1'b1 && k < 80) begin
      cyc(1);
      k++;
      if (bus_err === 1'b1) err_seen = 1'b1;
    end
    spur_seen = spur;
    chk(vec, v);
    chk(vaddr, vbase + {22'h0, v, 2'h0});
    cyc(1);
  endtask
  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    xtab = '{IPA_VEC_SPUR, XV, IPA_VEC_AUTO0 + 8'h4, XV};
    cyc(16);
    chk({mrst, trc_hi, trc_lo, sup, mask}, 7'h4f);
    chk(vbo, 32'h0);
    nrst_i = 1'b1;
    wait_run();
    pin_n = 1'b0;
    cause = 4'h5;
    cyc(4);
    pin_n = 1'b1;
    cyc(1);
    cause = 4'h0;
    cyc(2);
    chk(cause_reg, 4'h5);
    set_base(32'h0000_1000);
    set_mask(3'h2);
    rreq = 1'b1;
    cyc(5);
    chk(mrst, 1'b0);
    bdone = 1'b1;
    cyc(1);
    bdone = 1'b0;
    cyc(2);
    chk({mrst, mask}, 4'hf);
    chk(vbo, 32'h0);
    rreq = 1'b0;
    wait_run();
    set_base(32'h0000_2400);
    set_mask(3'h0);
    m_lvl = 12'h003;
    m_arb = 16'h0005;
    m_vec = 32'h0000_0061;
    ack(3'h3, 8'h61);
    clr();
    m_lvl = 12'h024;
    m_arb = 16'h0095;
    m_vec = 32'h0000_6362;
    ack(3'h4, 8'h63);
    chk(spur_seen, 1'b0);
    clr();
    m_lvl = 12'h002;
    m_arb = 16'h0000;
    ack(3'h2, IPA_VEC_SPUR);
    chk(spur_seen, 1'b1);
    clr();
    // silent, prompt, autovector and slow external answers
    for (int i = 0; i < 4; i++) begin
      mode = i[1:0];
      irq_n[i+2] = 1'b0;
      ack(3'(i + 2), xtab[i]);
      chk(err_seen, i == 0);
      clr();
    end
    mode = 2'h1;
    cyc(1);
    set_mask(3'h4);
    irq_n[4] = 1'b0;
    per = 1'b1;
    quiet(12);
    irq_n[6] = 1'b0;
    ack(3'h6, XV);
    clr();
    // timer request at its field level, held off until a boundary
    per_lvl = 3'h5;
    per = 1'b1;
    bnd = 1'b0;
    quiet(6);
    bnd = 1'b1;
    ack(3'h5, XV);
    clr();
    irq_n[5] = 1'b0;
    cyc(1);
    irq_n[5] = 1'b1;
    quiet(10);
    mode = 2'h2;
    set_mask(3'h7);
    irq_n[7] = 1'b0;
    ack(3'h7, IPA_VEC_AUTO0 + 8'h7);
    set_mask(3'h0);
    ack(3'h7, IPA_VEC_AUTO0 + 8'h7);
    clr();
    report_and_stop();
  end
endmodule
`default_nettype wire
